// ===== src/hwdt_pkg.sv
package hwdt_pkg;

    // ==========================================================
    // special-function addresses
    localparam logic [7:0] HWDT_SERVICE_ADDR = 8'ha6;
    localparam logic [7:0] HWDT_PRESCALE_ADDR = 8'ha7;

    // ==========================================================
    // service key bytes, first then second
    localparam logic [7:0] HWDT_KEY_FIRST = 8'h1e;
    localparam logic [7:0] HWDT_KEY_SECOND = 8'he1;

    // ==========================================================
    // counter geometry
    localparam int HWDT_COUNT_W = 14;
    localparam logic [HWDT_COUNT_W-1:0] HWDT_COUNT_MAX = 14'h3fff;
    localparam int HWDT_PRESC_W = 7;
    localparam int HWDT_SEL_W = 3;
    localparam logic [HWDT_SEL_W-1:0] HWDT_SEL_RESET = 3'h0;
    localparam logic [7:0] HWDT_READ_ZERO = 8'h00;

    // ==========================================================
    // machine cycle lengths in oscillator periods
    localparam int HWDT_MC_STD = 12;
    localparam int HWDT_MC_X2 = 6;
    localparam int HWDT_MC_W = 4;

    // ==========================================================
    // reset pulse length, in oscillator periods (clk_sys is the
    // oscillator, so one period is one clock cycle)
    localparam int HWDT_RST_PULSE_TOSC = 96;
    localparam int HWDT_RST_PULSE_CYC = HWDT_RST_PULSE_TOSC;
    localparam int HWDT_RST_W = 7;

    // ==========================================================
    // watchdog operating states
    typedef enum logic [1:0] {
        HWDT_DISABLED,
        HWDT_COUNTING,
        HWDT_RESETTING
    } hwdt_state_t;

endpackage

// ===== src/hwdt_machine_cycle.sv
`timescale 1ns/1ps

// ==========================================================
// machine cycle tick generator
module hwdt_machine_cycle #(
    parameter int MC_STD = hwdt_pkg::HWDT_MC_STD,
    parameter int MC_X2 = hwdt_pkg::HWDT_MC_X2,
    parameter int MC_W = hwdt_pkg::HWDT_MC_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic osc_running,
    input wire logic double_speed_mode,
    output logic mc_tick
);

    logic [MC_W-1:0] div_q;
    logic [MC_W-1:0] last;

    // last phase of a machine cycle depends on the speed mode
    assign last = double_speed_mode ? MC_W'(MC_X2 - 1)
                                    : MC_W'(MC_STD - 1);

    // divider holds still while the oscillator is stopped
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            div_q <= '0;
        end else if (osc_running) begin
            // >= guards a mode switch from 12 down to 6 mid-cycle
            if (div_q >= last) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + MC_W'(1);
            end
        end
    end

    // one pulse per machine cycle, only with the oscillator alive
    assign mc_tick = osc_running && (div_q >= last);

endmodule

// ===== src/hwdt_top.sv
`timescale 1ns/1ps

module hwdt_top #(
    parameter int COUNT_W = hwdt_pkg::HWDT_COUNT_W,
    parameter int PRESC_W = hwdt_pkg::HWDT_PRESC_W,
    parameter int SEL_W = hwdt_pkg::HWDT_SEL_W,
    parameter int RST_PULSE_CYC = hwdt_pkg::HWDT_RST_PULSE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic osc_running,
    input wire logic double_speed_mode,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic watchdog_enabled,
    output logic wdt_reset_out,
    output logic wdt_reset_oe_n
);

    // ==========================================================
    // declarations
    hwdt_pkg::hwdt_state_t state_q;
    logic [COUNT_W-1:0] count_q;
    logic [PRESC_W-1:0] presc_q;
    logic [SEL_W-1:0] sel_q;
    logic [hwdt_pkg::HWDT_RST_W-1:0] pulse_q;
    logic key_armed_q;
    logic [7:0] rdata_q;
    logic mc_tick;
    logic svc_wr;
    logic key_done;
    logic presc_mask_hit;
    logic count_tick;
    logic overflow;
    logic [PRESC_W-1:0] presc_mask;

    // ==========================================================
    // machine cycle source
    hwdt_machine_cycle #(
        .MC_STD(hwdt_pkg::HWDT_MC_STD),
        .MC_X2(hwdt_pkg::HWDT_MC_X2),
        .MC_W(hwdt_pkg::HWDT_MC_W)
    ) u_mc (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .osc_running(osc_running),
        .double_speed_mode(double_speed_mode),
        .mc_tick(mc_tick)
    );

    // ==========================================================
    // service key decode
    assign svc_wr = sfr_wr && (sfr_addr == hwdt_pkg::HWDT_SERVICE_ADDR);
    assign key_done = svc_wr && key_armed_q
                      && (sfr_wdata == hwdt_pkg::HWDT_KEY_SECOND);

    // first key arms; any other byte written to the service address drops the half-done sequence
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            key_armed_q <= 1'b0;
        end else if (svc_wr) begin
            // a repeated first key simply re-arms
            key_armed_q <= (sfr_wdata == hwdt_pkg::HWDT_KEY_FIRST);
        end
    end

    // ==========================================================
    // prescale select register, software visible
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sel_q <= hwdt_pkg::HWDT_SEL_RESET;
        end else if (sfr_wr
                     && (sfr_addr == hwdt_pkg::HWDT_PRESCALE_ADDR)) begin
            sel_q <= sfr_wdata[SEL_W-1:0];
        end
    end

    // ==========================================================
    // prescaler: counter steps once per 2^sel machine cycles
    assign presc_mask = PRESC_W'((1 << sel_q) - 1);
    assign presc_mask_hit = ((presc_q & presc_mask) == presc_mask);
    assign count_tick = (state_q == hwdt_pkg::HWDT_COUNTING)
                        && mc_tick && presc_mask_hit;

    // prescaler restarts with every service so the full period applies
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            presc_q <= '0;
        end else if (key_done
                     || state_q != hwdt_pkg::HWDT_COUNTING) begin
            presc_q <= '0;
        end else if (mc_tick) begin
            presc_q <= presc_q + PRESC_W'(1);
        end
    end

    // ==========================================================
    // overflow detect: next step would land on the top value
    assign overflow = count_tick
                      && (count_q + COUNT_W'(1) ==
                          COUNT_W'(hwdt_pkg::HWDT_COUNT_MAX));

    // watchdog counter; no software path reads or loads it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count_q <= '0;
        end else if (state_q != hwdt_pkg::HWDT_COUNTING) begin
            count_q <= '0;
        end else if (key_done) begin
            // service wins over a tick in the same cycle
            count_q <= '0;
        end else if (overflow) begin
            count_q <= '0;
        end else if (count_tick) begin
            count_q <= count_q + COUNT_W'(1);
        end
    end

    // ==========================================================
    // operating state
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_q <= hwdt_pkg::HWDT_DISABLED;
        end else begin
            unique case (state_q)
                hwdt_pkg::HWDT_DISABLED: begin
                    if (key_done) begin
                        state_q <= hwdt_pkg::HWDT_COUNTING;
                    end
                end
                hwdt_pkg::HWDT_COUNTING: begin
                    // no write turns it off; a service in the same cycle
                    // still rescues a tick that would overflow
                    if (overflow && !key_done) begin
                        state_q <= hwdt_pkg::HWDT_RESETTING;
                    end
                end
                hwdt_pkg::HWDT_RESETTING: begin
                    if (pulse_q == '0) begin
                        state_q <= hwdt_pkg::HWDT_DISABLED;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // reset pulse length counter
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pulse_q <= '0;
        end else if (state_q == hwdt_pkg::HWDT_COUNTING
                     && overflow && !key_done) begin
            pulse_q <= hwdt_pkg::HWDT_RST_W'(RST_PULSE_CYC - 1);
        end else if (pulse_q != '0) begin
            pulse_q <= pulse_q - hwdt_pkg::HWDT_RST_W'(1);
        end
    end

    // pin is high while resetting; enable low means driving
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wdt_reset_out <= 1'b0;
            wdt_reset_oe_n <= 1'b1;
        end else begin
            wdt_reset_out <= (state_q == hwdt_pkg::HWDT_COUNTING
                              && overflow && !key_done)
                             || (state_q == hwdt_pkg::HWDT_RESETTING
                                 && pulse_q != '0);
            wdt_reset_oe_n <= !((state_q == hwdt_pkg::HWDT_COUNTING
                                 && overflow && !key_done)
                                || (state_q == hwdt_pkg::HWDT_RESETTING
                                    && pulse_q != '0));
        end
    end

    // ==========================================================
    // read path: only the prescale select reads back
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdata_q <= hwdt_pkg::HWDT_READ_ZERO;
        end else if (sfr_rd
                     && sfr_addr == hwdt_pkg::HWDT_PRESCALE_ADDR) begin
            rdata_q <= {{(8-SEL_W){1'b0}}, sel_q};
        end else begin
            rdata_q <= hwdt_pkg::HWDT_READ_ZERO;
        end
    end

    assign sfr_rdata = rdata_q;

    // status flag for the rest of the device
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            watchdog_enabled <= 1'b0;
        end else begin
            watchdog_enabled <= (state_q == hwdt_pkg::HWDT_COUNTING);
        end
    end

endmodule

// ===== tb/hwdt_chk.sv
`timescale 1ns/1ps

// ==========================================================
// port-level checks for the watchdog
module hwdt_chk #(
    parameter int RST_PULSE_CYC = 96
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic watchdog_enabled,
    input wire logic wdt_reset_out,
    input wire logic wdt_reset_oe_n
);
    logic [7:0] hi_q;
    logic [2:0] lo_q;
    logic key2_w;
    logic rd_sel_w;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // second key byte and prescale read as seen at the ports
    assign key2_w = sfr_wr && sfr_addr == 8'ha6 && sfr_wdata == 8'he1;
    assign rd_sel_w = sfr_rd && sfr_addr == 8'ha7;
    // pulse length so far; a counter is cheaper than a long repetition
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !wdt_reset_out) begin
            hi_q <= 8'h00;
        end else begin
            hi_q <= hi_q + 8'h01;
        end
    end
    // cycles since the pulse ended, saturating
    always_ff @(posedge clk_sys) begin
        if (!reset_n || wdt_reset_out) begin
            lo_q <= 3'h0;
        end else if (lo_q != 3'h7) begin
            lo_q <= lo_q + 3'h1;
        end
    end
    chk_oe_follows_pin: assert property (
        wdt_reset_oe_n == !wdt_reset_out)
        else $error("reset pin enable does not follow the pulse");
    chk_pulse_exact_len: assert property (
        $fell(wdt_reset_out) |-> hi_q == RST_PULSE_CYC)
        else $error("reset pulse has the wrong length");
    chk_pulse_not_long: assert property (
        wdt_reset_out |-> hi_q < RST_PULSE_CYC)
        else $error("reset pulse runs too long");
    // the first key must not fall in reset, which clears the arm
    chk_key_enables: assert property (
        key2_w && $past(reset_n) && $past(sfr_wr)
        && $past(sfr_addr) == 8'ha6 && $past(sfr_wdata) == 8'h1e
        && !wdt_reset_out |-> ##2 watchdog_enabled)
        else $error("key pair did not enable");
    chk_enable_cause: assert property (
        $rose(watchdog_enabled) |-> $past(key2_w, 2))
        else $error("enabled without a completed key");
    chk_stays_on: assert property (
        $fell(watchdog_enabled) |-> wdt_reset_out || lo_q < 3'h4)
        else $error("watchdog turned off without overflow");
    chk_pulse_cause: assert property (
        $rose(wdt_reset_out) |-> $past(watchdog_enabled))
        else $error("reset pulse while disabled");
    chk_read_only_sel: assert property (
        !$past(rd_sel_w) |-> sfr_rdata == 8'h00)
        else $error("nonzero read data outside prescale read");
    chk_sel_width: assert property (
        sfr_rdata[7:3] == 5'h00)
        else $error("prescale read has upper bits set");
endmodule

bind hwdt_top hwdt_chk #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .watchdog_enabled(watchdog_enabled),
    .wdt_reset_out(wdt_reset_out), .wdt_reset_oe_n(wdt_reset_oe_n));

// ===== tb/hwdt_top_test.sv
`timescale 1ns/1ps

// ==========================================================
// self-checking bench, inputs driven on the falling edge
module hwdt_top_test;
    localparam int PULSE_CYC = 96;
    // cycles left after the slow, stopped and prescaled phases, which
    // together use up 100 of the 16383 steps
    localparam int LEFT_CYC = (16383 - 600 / 12 - 600 / 12) * 6;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic osc_running = 1'b1;
    logic double_speed_mode = 1'b1;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic watchdog_enabled, wdt_reset_out, wdt_reset_oe_n;
    int n_errors = 0;
    int n_checks = 0;
    int n;
    hwdt_top #(.RST_PULSE_CYC(PULSE_CYC)) i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .osc_running(osc_running),
        .double_speed_mode(double_speed_mode), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .watchdog_enabled(watchdog_enabled),
        .wdt_reset_out(wdt_reset_out), .wdt_reset_oe_n(wdt_reset_oe_n));
    always #5 clk_sys = ~clk_sys;
    // ==========================================================
    // bus tasks; writes chain back to back until idle or rd lowers them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
    endtask
    task automatic idle(input int c);
        repeat (c) begin
            @(negedge clk_sys);
            sfr_wr = 1'b0;
            sfr_rd = 1'b0;
        end
    endtask
    task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask
    // read data stands for the one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        sfr_wr = 1'b0;
        sfr_rd = 1'b1;
        sfr_addr = a;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        check_eq(sfr_rdata, exp);
    endtask
    function automatic logic [7:0] flags();
        return {5'h00, watchdog_enabled, wdt_reset_out, wdt_reset_oe_n};
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==========================================================
    // hang guard, sized for one full timeout plus the short tests
    initial begin
        repeat (105000) @(posedge clk_sys);
        n_errors++;
        give_verdict();
    end
    initial begin
        idle(2);
        reset_n = 1'b1;
        check_eq(flags(), 8'h01);
        idle(20);
        check_eq(flags(), 8'h01);
        $display("reset state done");
        wr(8'ha6, 8'he1);
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'h55);
        wr(8'ha6, 8'he1);
        idle(4);
        check_eq(flags(), 8'h01);
        rd(8'ha6, 8'h00);
        wr(8'ha7, 8'h05);
        rd(8'ha7, 8'h05);
        wr(8'ha7, 8'h00);
        idle(1);
        $display("refusals done");
        wr(8'ha6, 8'h1e);
        wr(8'h80, 8'h00);
        wr(8'ha6, 8'he1);
        idle(3);
        check_eq(flags(), 8'h05);
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'h55);
        wr(8'ha6, 8'h00);
        idle(4);
        check_eq(flags(), 8'h05);
        $display("enable done");
        // service late enough that an unrestarted count would fire early
        idle(300);
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'he1);
        // slow cycles, a stopped oscillator and a halving prescaler each
        // hold back about 50 steps; a broken one overflows 300 early
        double_speed_mode = 1'b0;
        idle(600);
        osc_running = 1'b0;
        double_speed_mode = 1'b1;
        idle(300);
        osc_running = 1'b1;
        wr(8'ha7, 8'h01);
        idle(599);
        wr(8'ha7, 8'h00);
        idle(1);
        n = 0;
        while (!wdt_reset_out && n < 100000) begin
            @(negedge clk_sys);
            n++;
        end
        check_eq(8'(n > LEFT_CYC - 36), 8'h01);
        check_eq(8'(n < LEFT_CYC + 36), 8'h01);
        n = 0;
        while (wdt_reset_out && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        check_eq(8'(n), 8'(PULSE_CYC));
        idle(4);
        check_eq(flags(), 8'h01);
        $display("overflow done");
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'he1);
        idle(3);
        check_eq(flags(), 8'h05);
        reset_n = 1'b0;
        idle(2);
        reset_n = 1'b1;
        idle(2);
        check_eq(flags(), 8'h01);
        $display("second reset done");
        give_verdict();
    end
endmodule
